// File: epti_top.sv
`timescale 1ns/1ps
module epti_top (
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Port pins and peripheral events
    input  wire logic [epti_pkg::PIN_N-1:0] port_pins,
    input  wire logic [7:0]                 periph_event,
    // Processor core
    input  wire logic                       core_sleep,
    input  wire logic                       core_irq_ack,
    input  wire logic                       core_irq_ret,
    input  wire logic [epti_pkg::PC_W-1:0]  core_ret_pc,
    input  wire logic [1:0]                 core_bank,
    input  wire logic [6:0]                 core_offset,
    output logic                            irq_request,
    output logic                            wake_request,
    output logic                            pc_load,
    output logic      [epti_pkg::PC_W-1:0]  pc_value,
    output logic      [8:0]                 phys_addr
);

    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] off);
        addr_is = (a == off);
    endfunction

    // Register state
    epti_pkg::epti_ctrl_t          ctrl_r;
    epti_pkg::epti_ctrl_t          ctrl_nxt;
    logic [7:0]                    pie_r;
    logic [7:0]                    pir_r;
    logic [7:0]                    pir_nxt;
    logic                          edge_sel_r;
    logic [epti_pkg::PIN_N-1:0]    chg_sel_r;
    logic [epti_pkg::PIN_N-1:0]    ana_sel_r;
    logic [7:0]                    timer_r;
    logic [7:0]                    timer_nxt;
    logic [epti_pkg::PIN_N-1:0]    chg_latch_r;
    epti_pkg::epti_phase_t         phase_r;
    epti_pkg::epti_phase_t         phase_nxt;
    logic                          int_prev_r;
    logic                          int_pend_r;
    logic                          sleep_prev_r;
    logic                          wake_arm_r;
    logic [epti_pkg::SP_W-1:0]     sp_r;
    logic [epti_pkg::PC_W-1:0]     stack_mem [0:(1<<epti_pkg::SP_W)-1];
    logic [31:0]                   prdata_r;
    logic                          pc_load_r;
    logic [epti_pkg::PC_W-1:0]     pc_value_r;

    // APB decode
    wire       wr_acc    = psel & penable & pwrite;
    wire       rd_setup  = psel & ~penable & ~pwrite;
    wire       hit_ctrl  = addr_is(paddr, epti_pkg::ADDR_CTRL);
    wire       hit_pie   = addr_is(paddr, epti_pkg::ADDR_PIE);
    wire       hit_pir   = addr_is(paddr, epti_pkg::ADDR_PIR);
    wire       hit_edge  = addr_is(paddr, epti_pkg::ADDR_EDGE);
    wire       hit_chg   = addr_is(paddr, epti_pkg::ADDR_CHGSEL);
    wire       hit_ana   = addr_is(paddr, epti_pkg::ADDR_ANASEL);
    wire       hit_tmr   = addr_is(paddr, epti_pkg::ADDR_TIMER);
    wire       hit_port  = addr_is(paddr, epti_pkg::ADDR_PORT);
    wire       addr_hit  = hit_ctrl | hit_pie | hit_pir | hit_edge |
                           hit_chg | hit_ana | hit_tmr | hit_port;
    wire       wr_ctrl   = wr_acc & hit_ctrl;
    wire       wr_pir    = wr_acc & hit_pir;
    wire       wr_tmr    = wr_acc & hit_tmr;
    wire       port_read = rd_setup & hit_port;

    // Synchronised port levels
    logic [epti_pkg::PIN_N-1:0] pin_lvl;
    genvar g;
    generate
        for (g = 0; g < epti_pkg::PIN_N; g++) begin : g_sync
            epti_pin_sync u_sync (
                .clk       (pclk),
                .rst_n     (presetn),
                .pin_in    (port_pins[g]),
                .level_out (pin_lvl[g])
            );
        end
    endgenerate

    // Analog pins read as zero; change logic sees the same digital view
    wire [epti_pkg::PIN_N-1:0] port_dig = pin_lvl & ~ana_sel_r;

    // Instruction cycle phase sequencer
    always_comb begin
        unique case (phase_r)
            epti_pkg::EPTI_Q1: phase_nxt = epti_pkg::EPTI_Q2;
            epti_pkg::EPTI_Q2: phase_nxt = epti_pkg::EPTI_Q3;
            epti_pkg::EPTI_Q3: phase_nxt = epti_pkg::EPTI_Q4;
            epti_pkg::EPTI_Q4: phase_nxt = epti_pkg::EPTI_Q1;
        endcase
    end
    wire inst_end   = (phase_r == epti_pkg::EPTI_Q4);
    wire int_window = (phase_r == epti_pkg::EPTI_Q4) |
                      (phase_r == epti_pkg::EPTI_Q1);

    // External pin edge; an edge outside Q4-Q1 waits for the next window
    wire int_lvl    = pin_lvl[epti_pkg::INT_PIN];
    wire int_rise   = int_lvl & ~int_prev_r;
    wire int_fall   = ~int_lvl & int_prev_r;
    wire int_edge   = edge_sel_r ? int_rise : int_fall;
    wire edge_set   = (int_edge | int_pend_r) & int_window;
    wire int_pend_n = (int_edge | int_pend_r) & ~int_window;

    // Port change; a read in the same cycle re-arms the latch and may mask it
    wire chg_diff = |((port_dig ^ chg_latch_r) & chg_sel_r);
    wire port_set = chg_diff & ~port_read;

    // Timer rollover
    wire tmr_ovf = inst_end & (timer_r == epti_pkg::TIMER_MAX) & ~wr_tmr;
    assign timer_nxt = wr_tmr   ? pwdata[7:0] :
                       inst_end ? timer_r + epti_pkg::TIMER_ONE : timer_r;

    // Flag and enable updates: events OR in after the software write
    always_comb begin
        ctrl_nxt = wr_ctrl ? epti_pkg::epti_ctrl_t'(pwdata[7:0]) : ctrl_r;
        ctrl_nxt.pin_irq_flag = ctrl_nxt.pin_irq_flag | edge_set;
        ctrl_nxt.timer_overflow_flag =
            ctrl_nxt.timer_overflow_flag | tmr_ovf;
        ctrl_nxt.port_change_flag =
            ctrl_nxt.port_change_flag | port_set;
        if (core_irq_ack) begin
            ctrl_nxt.global_irq_enable = 1'b0;
        end else if (core_irq_ret) begin
            ctrl_nxt.global_irq_enable = 1'b1;
        end
    end
    assign pir_nxt = (wr_pir ? pwdata[7:0] : pir_r) | periph_event;

    // Request qualification
    wire peri_req  = ctrl_r.peripheral_group_enable & |(pir_r & pie_r);
    wire pin_req   = ctrl_r.pin_irq_flag & ctrl_r.pin_irq_enable;
    wire tmr_req   = ctrl_r.timer_overflow_flag &
                     ctrl_r.timer_overflow_enable;
    wire chg_req   = ctrl_r.port_change_flag & ctrl_r.port_change_enable;
    wire any_req   = pin_req | tmr_req | chg_req | peri_req;
    // A pending flag must be cleared before re-enable or it re-requests
    assign irq_request = ctrl_r.global_irq_enable & any_req;

    // Wake ignores the global enable; the core then branches only on request
    wire wake_pin = ctrl_r.pin_irq_flag & wake_arm_r;
    assign wake_request = core_sleep & (wake_pin | tmr_req | chg_req |
                                        peri_req);

    // Common low bytes alias bank zero
    assign phys_addr = (core_offset < epti_pkg::COMMON_LIMIT) ?
                       {epti_pkg::COMMON_BANK, core_offset} :
                       {core_bank, core_offset};

    // Read mux
    wire [7:0] rd_byte =
        hit_ctrl ? ctrl_r :
        hit_pie  ? pie_r :
        hit_pir  ? pir_r :
        hit_edge ? {epti_pkg::EDGE_PAD, edge_sel_r} :
        hit_chg  ? {epti_pkg::PIN_PAD, chg_sel_r} :
        hit_ana  ? {epti_pkg::PIN_PAD, ana_sel_r} :
        hit_tmr  ? timer_r :
        hit_port ? {epti_pkg::PIN_PAD, port_dig} : 8'h00;

    // Zero wait states; data is captured in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;
    assign prdata  = prdata_r;
    assign pc_load  = pc_load_r;
    assign pc_value = pc_value_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= epti_pkg::epti_ctrl_t'(epti_pkg::CTRL_RST);
            pir_r      <= epti_pkg::PIR_RST;
            timer_r    <= epti_pkg::TIMER_RST;
            phase_r    <= epti_pkg::EPTI_Q1;
            int_prev_r <= 1'b0;
            int_pend_r <= 1'b0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            pir_r      <= pir_nxt;
            timer_r    <= timer_nxt;
            phase_r    <= phase_nxt;
            int_prev_r <= int_lvl;
            int_pend_r <= int_pend_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pie_r      <= epti_pkg::PIE_RST;
            edge_sel_r <= epti_pkg::EDGE_RST;
            chg_sel_r  <= epti_pkg::CHGSEL_RST;
            ana_sel_r  <= epti_pkg::ANASEL_RST;
        end else if (wr_acc) begin
            if (hit_pie)  pie_r      <= pwdata[7:0];
            if (hit_edge) edge_sel_r <= pwdata[0];
            if (hit_chg)  chg_sel_r  <= pwdata[epti_pkg::PIN_N-1:0];
            if (hit_ana)  ana_sel_r  <= pwdata[epti_pkg::PIN_N-1:0];
        end
    end

    // Port read re-arms the change comparison, as on the real port latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_latch_r <= '0;
            prdata_r    <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_r <= {epti_pkg::RD_PAD, rd_byte};
            if (hit_port) chg_latch_r <= port_dig;
        end
    end

    // Pin enable is frozen on sleep entry so later writes cannot arm a wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_prev_r <= 1'b0;
            wake_arm_r   <= 1'b0;
        end else begin
            sleep_prev_r <= core_sleep;
            if (core_sleep & ~sleep_prev_r) begin
                wake_arm_r <= ctrl_r.pin_irq_enable;
            end
        end
    end

    // Return stack; only the return address is kept, and it wraps when full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_r       <= epti_pkg::SP_RST;
            pc_load_r  <= 1'b0;
            pc_value_r <= '0;
        end else begin
            pc_load_r <= core_irq_ack | core_irq_ret;
            if (core_irq_ack) begin
                sp_r       <= sp_r + epti_pkg::SP_ONE;
                pc_value_r <= epti_pkg::IRQ_VECTOR;
            end else if (core_irq_ret) begin
                sp_r       <= sp_r - epti_pkg::SP_ONE;
                pc_value_r <= stack_mem[sp_r - epti_pkg::SP_ONE];
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (core_irq_ack) begin
            stack_mem[sp_r] <= core_ret_pc;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_late_edge;
        int_edge && !int_window;
    endsequence
    sequence s_service;
        core_irq_ack ##1 (pc_load && pc_value == epti_pkg::IRQ_VECTOR);
    endsequence

    a_edge_sets_flag: assert property (int_edge && int_window |=>
        ctrl_r.pin_irq_flag) else $error("pin edge did not set flag");
    a_polarity_fall: assert property (
        !edge_sel_r && int_rise |-> !int_edge)
        else $error("rising edge taken in falling mode");
    a_flag_window: assert property (s_late_edge |->
        ##[1:3] ctrl_r.pin_irq_flag) else $error("late edge never applied");
    a_flag_phase: assert property (
        $rose(ctrl_r.pin_irq_flag) && !$past(wr_ctrl) |->
        $past(int_window)) else $error("pin flag set outside window");
    a_pin_masked: assert property (
        !ctrl_r.pin_irq_enable && !tmr_req && !chg_req && !peri_req |->
        !irq_request) else $error("masked pin requested");
    a_gie_gate: assert property (!ctrl_r.global_irq_enable |->
        !irq_request) else $error("request with global enable clear");
    a_pin_raises: assert property (
        pin_req && ctrl_r.global_irq_enable |-> irq_request)
        else $error("enabled pin did not request");
    a_wake_prior: assert property (
        core_sleep && $stable(core_sleep) && !wake_arm_r && !tmr_req &&
        !chg_req && !peri_req |-> !wake_request)
        else $error("wake without prior enable");
    a_timer_roll: assert property (
        tmr_ovf |=> ctrl_r.timer_overflow_flag && timer_r == 8'h00)
        else $error("rollover not flagged");
    a_timer_mask: assert property (
        !ctrl_r.timer_overflow_enable && !pin_req && !chg_req &&
        !peri_req |-> !irq_request) else $error("masked timer requested");
    a_change_flag: assert property (port_set |=>
        ctrl_r.port_change_flag) else $error("change not flagged");
    a_analog_zero: assert property (port_read |=>
        (prdata[5:0] & $past(ana_sel_r)) == 6'h00)
        else $error("analog pin read nonzero");
    a_service_seq: assert property (core_irq_ack |-> s_service)
        else $error("service did not load vector");
    a_service_clear: assert property (core_irq_ack |=>
        !ctrl_r.global_irq_enable) else $error("service kept global enable");
    a_stack_push: assert property (core_irq_ack |=>
        sp_r == $past(sp_r) + epti_pkg::SP_ONE) else $error("no push");
    a_ret_enable: assert property (core_irq_ret && !core_irq_ack |=>
        ctrl_r.global_irq_enable) else $error("return kept enable clear");
    a_peri_group: assert property (
        !ctrl_r.peripheral_group_enable && !pin_req && !tmr_req &&
        !chg_req |-> !irq_request) else $error("peripheral group leaked");
    a_set_wins: assert property (
        wr_ctrl && !pwdata[1] && edge_set |=> ctrl_r.pin_irq_flag)
        else $error("clear beat event");
    a_common_bank: assert property (
        core_offset < epti_pkg::COMMON_LIMIT |-> phys_addr[8:7] == 2'h0)
        else $error("common byte not aliased");
endmodule

// File: epti_pkg.sv
package epti_pkg;

    // Register byte addresses on the APB bus
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_PIE    = 8'h04;
    localparam logic [7:0] ADDR_PIR    = 8'h08;
    localparam logic [7:0] ADDR_EDGE   = 8'h0c;
    localparam logic [7:0] ADDR_CHGSEL = 8'h10;
    localparam logic [7:0] ADDR_ANASEL = 8'h14;
    localparam logic [7:0] ADDR_TIMER  = 8'h18;
    localparam logic [7:0] ADDR_PORT   = 8'h1c;

    // Reset values
    localparam logic [7:0] CTRL_RST    = 8'h00;
    localparam logic [7:0] PIE_RST     = 8'h00;
    localparam logic [7:0] PIR_RST     = 8'h00;
    localparam logic       EDGE_RST    = 1'b1;
    localparam logic [5:0] CHGSEL_RST  = 6'h00;
    localparam logic [5:0] ANASEL_RST  = 6'h3f;
    localparam logic [7:0] TIMER_RST   = 8'h00;

    // Port and core geometry
    localparam int         PIN_N       = 6;
    localparam int         INT_PIN     = 2;
    localparam int         PC_W        = 13;
    localparam int         SP_W        = 3;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
    localparam logic [7:0] TIMER_MAX   = 8'hff;
    localparam logic [7:0] TIMER_ONE   = 8'h01;
    localparam logic [SP_W-1:0] SP_ONE = 3'h1;
    localparam logic [SP_W-1:0] SP_RST = 3'h0;
    localparam logic [6:0] COMMON_LIMIT = 7'h10;
    localparam logic [1:0] COMMON_BANK  = 2'h0;
    localparam logic [23:0] RD_PAD      = 24'h000000;
    localparam logic [1:0]  PIN_PAD     = 2'h0;
    localparam logic [6:0]  EDGE_PAD    = 7'h00;

    // Instruction cycle phases, Gray coded
    typedef enum logic [1:0] {
        EPTI_Q1 = 2'b00,
        EPTI_Q2 = 2'b01,
        EPTI_Q3 = 2'b11,
        EPTI_Q4 = 2'b10
    } epti_phase_t;

    // Layout of the interrupt control register, bit 7 down to bit 0
    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_group_enable;
        logic timer_overflow_enable;
        logic pin_irq_enable;
        logic port_change_enable;
        logic timer_overflow_flag;
        logic pin_irq_flag;
        logic port_change_flag;
    } epti_ctrl_t;

endpackage

// File: epti_pin_sync.sv
`timescale 1ns/1ps
module epti_pin_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Asynchronous pin and its filtered level
    input  wire logic pin_in,
    output logic      level_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // A change only counts once two late stages agree, masking one-off glitches
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r      <= 1'b0;
            s2_r      <= 1'b0;
            s3_r      <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule

// File: epti_core_model.sv
`timescale 1ns/1ps
module epti_core_model #(
    parameter int SVC = 40
) (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // Bench control
    input  wire logic                      ack_en,
    input  wire logic [7:0]                ack_dly,
    // Block side
    input  wire logic                      irq_request,
    output logic                           core_irq_ack,
    output logic                           core_irq_ret,
    output logic      [epti_pkg::PC_W-1:0] core_ret_pc
);
    logic [7:0] cnt_r;
    logic       busy_r;

    // Only the return address travels to the block; nothing else is saved
    assign core_ret_pc = 13'h0123;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r        <= 8'h00;
            busy_r       <= 1'b0;
            core_irq_ack <= 1'b0;
            core_irq_ret <= 1'b0;
        end else begin
            core_irq_ack <= 1'b0;
            core_irq_ret <= 1'b0;
            cnt_r        <= 8'h00;
            if (busy_r) begin
                // Service time is long enough for the handler to clear flags
                cnt_r <= cnt_r + 8'h01;
                if (cnt_r == SVC[7:0]) begin
                    core_irq_ret <= 1'b1;
                    busy_r      <= 1'b0;
                end
            end else if (ack_en && irq_request) begin
                cnt_r <= cnt_r + 8'h01;
                if (cnt_r == ack_dly) begin
                    core_irq_ack <= 1'b1;
                    busy_r       <= 1'b1;
                    cnt_r        <= 8'h00;
                end
            end
        end
    end
endmodule

// File: epti_top_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module epti_top_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0, periph_event = 0, ack_dly = 8'h03;
    logic [31:0] pwdata = 0, prdata, q;
    logic        pready, pslverr, e, core_sleep = 0, ack_en = 0;
    logic [5:0]  port_pins = 6'h3b;
    logic [1:0]  core_bank = 0;
    logic [6:0]  core_offset = 0;
    logic        core_irq_ack, core_irq_ret, irq_request, wake_request;
    logic        pc_load;
    logic [12:0] core_ret_pc, pc_value, last_pc;
    logic [8:0]  phys_addr;
    int          err_total = 0, checked = 0, loads = 0;

    epti_top epti_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_pins(port_pins), .periph_event(periph_event),
        .core_sleep(core_sleep), .core_irq_ack(core_irq_ack),
        .core_irq_ret(core_irq_ret), .core_ret_pc(core_ret_pc),
        .core_bank(core_bank), .core_offset(core_offset),
        .irq_request(irq_request), .wake_request(wake_request),
        .pc_load(pc_load), .pc_value(pc_value), .phys_addr(phys_addr));
    epti_core_model epti_core_model_i (.pclk(pclk), .presetn(presetn),
        .ack_en(ack_en), .ack_dly(ack_dly), .irq_request(irq_request),
        .core_irq_ack(core_irq_ack), .core_irq_ret(core_irq_ret),
        .core_ret_pc(core_ret_pc));

    initial begin
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (pc_load === 1'b1) begin
            loads++;
            last_pc <= pc_value;
        end
    end

    task automatic tally_and_finish;
        $display("Checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) err_total++;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        `CHK(q, {24'h000000, x})
    endtask
    // Synchroniser plus phase wait stays well inside 12 cycles
    task automatic pin(input int i, input logic v);
        @(posedge pclk);
        port_pins[i] <= v;
        repeat (12) @(posedge pclk);
    endtask
    task automatic irq(input logic x);
        @(posedge pclk);
        `CHK(irq_request, x)
    endtask

    task automatic t_regs;
        rdc(epti_pkg::ADDR_CTRL, epti_pkg::CTRL_RST);
        rdc(epti_pkg::ADDR_PIE, epti_pkg::PIE_RST);
        rdc(epti_pkg::ADDR_PIR, epti_pkg::PIR_RST);
        rdc(epti_pkg::ADDR_EDGE, {7'h00, epti_pkg::EDGE_RST});
        rdc(epti_pkg::ADDR_CHGSEL, {2'h0, epti_pkg::CHGSEL_RST});
        rdc(epti_pkg::ADDR_ANASEL, {2'h0, epti_pkg::ANASEL_RST});
        rdc(epti_pkg::ADDR_PORT, 8'h00);
        apb(1'b0, 8'h20, 8'h00);
        `CHK(e, 1'b1)
        `CHK(q, 32'h00000000)
        $display("t_regs done");
    endtask
    task automatic t_pin;
        wr(epti_pkg::ADDR_ANASEL, 8'h00);
        wr(epti_pkg::ADDR_CTRL, 8'h10);
        pin(2, 1'b1);
        rdc(epti_pkg::ADDR_CTRL, 8'h12);
        irq(1'b0);
        wr(epti_pkg::ADDR_CTRL, 8'h82);
        irq(1'b0);
        wr(epti_pkg::ADDR_CTRL, 8'h80);
        pin(2, 1'b0);
        rdc(epti_pkg::ADDR_CTRL, 8'h80);
        wr(epti_pkg::ADDR_EDGE, 8'h00);
        pin(2, 1'b1);
        rdc(epti_pkg::ADDR_CTRL, 8'h80);
        pin(2, 1'b0);
        rdc(epti_pkg::ADDR_CTRL, 8'h82);
        wr(epti_pkg::ADDR_CTRL, 8'h00);
        wr(epti_pkg::ADDR_EDGE, 8'h01);
        $display("t_pin done");
    endtask
    task automatic t_service;
        int n;
        ack_en <= 1'b1;
        wr(epti_pkg::ADDR_CTRL, 8'h90);
        pin(2, 1'b1);
        // Ack delay plus the registered load can run past the pin wait
        repeat (4) @(posedge pclk);
        `CHK(loads, 1)
        `CHK(last_pc, epti_pkg::IRQ_VECTOR)
        rdc(epti_pkg::ADDR_CTRL, 8'h12);
        wr(epti_pkg::ADDR_CTRL, 8'h10);
        n = 0;
        while (loads < 2 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        `CHK(last_pc, core_ret_pc)
        rdc(epti_pkg::ADDR_CTRL, 8'h90);
        irq(1'b0);
        ack_en <= 1'b0;
        wr(epti_pkg::ADDR_CTRL, 8'h00);
        $display("t_service done");
    endtask
    task automatic t_timer;
        wr(epti_pkg::ADDR_CTRL, 8'h20);
        wr(epti_pkg::ADDR_TIMER, 8'hfe);
        repeat (12) @(posedge pclk);
        rdc(epti_pkg::ADDR_CTRL, 8'h24);
        irq(1'b0);
        wr(epti_pkg::ADDR_CTRL, 8'h84);
        irq(1'b0);
        wr(epti_pkg::ADDR_CTRL, 8'ha4);
        irq(1'b1);
        wr(epti_pkg::ADDR_CTRL, 8'h00);
        $display("t_timer done");
    endtask
    task automatic t_change;
        wr(epti_pkg::ADDR_ANASEL, 8'h02);
        wr(epti_pkg::ADDR_CHGSEL, 8'h01);
        rdc(epti_pkg::ADDR_PORT, 8'h3d);
        wr(epti_pkg::ADDR_CTRL, 8'h08);
        // A digital pin left out of the select must not flag
        pin(3, 1'b0);
        rdc(epti_pkg::ADDR_CTRL, 8'h08);
        pin(0, 1'b0);
        rdc(epti_pkg::ADDR_CTRL, 8'h09);
        wr(epti_pkg::ADDR_CTRL, 8'h89);
        irq(1'b1);
        wr(epti_pkg::ADDR_CTRL, 8'h81);
        irq(1'b0);
        rdc(epti_pkg::ADDR_PORT, 8'h34);
        wr(epti_pkg::ADDR_CHGSEL, 8'h00);
        wr(epti_pkg::ADDR_CTRL, 8'h00);
        $display("t_change done");
    endtask
    task automatic t_periph;
        wr(epti_pkg::ADDR_PIE, 8'h01);
        wr(epti_pkg::ADDR_CTRL, 8'h80);
        @(posedge pclk);
        periph_event <= 8'h01;
        @(posedge pclk);
        periph_event <= 8'h00;
        rdc(epti_pkg::ADDR_PIR, 8'h01);
        irq(1'b0);
        wr(epti_pkg::ADDR_CTRL, 8'hc0);
        irq(1'b1);
        wr(epti_pkg::ADDR_PIE, 8'h00);
        irq(1'b0);
        wr(epti_pkg::ADDR_PIR, 8'h00);
        wr(epti_pkg::ADDR_CTRL, 8'h00);
        $display("t_periph done");
    endtask
    task automatic t_wake;
        wr(epti_pkg::ADDR_CTRL, 8'h10);
        @(posedge pclk);
        core_sleep <= 1'b1;
        pin(2, 1'b0);
        pin(2, 1'b1);
        `CHK(wake_request, 1'b1)
        irq(1'b0);
        core_sleep <= 1'b0;
        wr(epti_pkg::ADDR_CTRL, 8'h00);
        core_sleep <= 1'b1;
        wr(epti_pkg::ADDR_CTRL, 8'h10);
        pin(2, 1'b0);
        pin(2, 1'b1);
        `CHK(wake_request, 1'b0)
        core_sleep <= 1'b0;
        wr(epti_pkg::ADDR_CTRL, 8'h00);
        $display("t_wake done");
    endtask
    task automatic t_bank;
        @(posedge pclk);
        core_bank   <= 2'h2;
        core_offset <= 7'h05;
        repeat (2) @(posedge pclk);
        `CHK(phys_addr, 9'h005)
        core_offset <= 7'h10;
        repeat (2) @(posedge pclk);
        `CHK(phys_addr, 9'h110)
        $display("t_bank done");
    endtask

    initial begin
        // Budget is 50000 cycles, far above the few hundred the run needs; this only catches a hang
        #200000;
        err_total++;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_pin;
        t_service;
        t_timer;
        t_change;
        t_periph;
        t_wake;
        t_bank;
        tally_and_finish;
    end
endmodule
